// ### hw/gbtrd_core.sv
`timescale 1ns/10ps
// Behaviour
// RULE1: x offset is 16-bit signed, high byte at 0x13, low at 0x14, read/write
// RULE2: y offset is 16-bit signed, high byte at 0x15, low at 0x16, read/write
// RULE3: z offset is 16-bit signed, high byte at 0x17, low at 0x18, read/write
// RULE4: each axis output equals raw sample plus its signed offset
// RULE5: output rate is internal rate divided by one plus divisor at 0x19
// RULE6: internal rate that gets divided is one kilohertz
// RULE7: divisor only acts with bypass bits zero and lowpass setting within 1..6
// RULE8: divided rate updates output registers and paces fifo writes
// RULE9: bypass select bits are gyro configuration bits 1 and 0
module gbtrd_core #(
    parameter int TICK_CYCLES = gbtrd_pkg::GBTRD_TICK_CYCLES
) (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      ce,
    input  wire gbtrd_pkg::gbtrd_reg_req_t reg_req,
    output logic [7:0]                     reg_rdata,
    input  wire logic                      raw_valid,
    input  wire gbtrd_pkg::gbtrd_axes_t    raw_sample,
    output gbtrd_pkg::gbtrd_axes_t         gyro_out,
    output logic                           sample_strobe,
    output logic                           fifo_write
);
    import gbtrd_pkg::*;

    // the counter is 24 bits wide and needs two cycles to give a one-cycle tick
    generate
        if (TICK_CYCLES < 2 || TICK_CYCLES > (1 << 24)) begin : g_bad_tick
            $error("tick count out of range");
        end
        // trim decode adds the byte index to the first address, so the six must stay consecutive
        if (GBTRD_ADDR_Z_LOW != GBTRD_ADDR_X_HIGH + 8'h05) begin : g_bad_trim_map
            $error("trim addresses not consecutive");
        end
        if (GBTRD_LOWPASS_LSB + 3 > 8 || GBTRD_BYPASS_LSB + 2 > 8) begin : g_bad_field
            $error("filter field outside its byte");
        end
    endgenerate

    localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);

    logic [7:0]         trim_byte [0:5];
    logic [7:0]         output_rate_divisor_value;
    logic [7:0]         config_reg;
    logic [7:0]         gyro_cfg;
    logic [1:0]         filter_bypass_select;
    logic [2:0]         lowpass_setting;
    logic               divider_active;

    logic [23:0]        tick_cnt;
    logic               internal_tick;
    logic [7:0]         div_cnt;
    logic               next_strobe;

    gbtrd_axes_t        held_raw;
    gbtrd_axes_t        trimmed;
    logic signed [15:0] x_bias_trim_value;
    logic signed [15:0] y_bias_trim_value;
    logic signed [15:0] z_bias_trim_value;
    logic signed [15:0] raw_axis  [0:2];
    logic signed [15:0] trim_axis [0:2];
    logic signed [15:0] sum_axis  [0:2];

    // the six trim bytes sit at consecutive addresses
    function automatic logic trim_hit(input logic [7:0] a, input int idx);
        return a == GBTRD_ADDR_X_HIGH + 8'(idx);
    endfunction

    // low-pass codes 0 and 7 keep the fast internal rate, so the divisor is ignored there
    function automatic logic divider_applies(input logic [1:0] bypass, input logic [2:0] lowpass);
        return (bypass == GBTRD_BYPASS_OFF)
            && (lowpass != 3'h0)
            && (lowpass != GBTRD_LOWPASS_MAX);
    endfunction

    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_trim
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    trim_byte[g] <= GBTRD_RESET_BYTE;
                end else if (ce && reg_req.wr && trim_hit(reg_req.addr, g)) begin
                    trim_byte[g] <= reg_req.wdata; // RULE1 RULE2 RULE3
                end
            end
        end
    endgenerate

    assign x_bias_trim_value = {trim_byte[0], trim_byte[1]}; // RULE1
    assign y_bias_trim_value = {trim_byte[2], trim_byte[3]}; // RULE2
    assign z_bias_trim_value = {trim_byte[4], trim_byte[5]}; // RULE3

    // a write lands on the edge that takes it; the read mux shows it one cycle on
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            output_rate_divisor_value <= GBTRD_RESET_BYTE;
        end else if (ce && reg_req.wr && reg_req.addr == GBTRD_ADDR_DIVISOR) begin
            output_rate_divisor_value <= reg_req.wdata; // RULE5
        end
    end

    // bit 7 resets high; only the low-pass field below it acts here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            config_reg <= GBTRD_RESET_CONFIG;
        end else if (ce && reg_req.wr && reg_req.addr == GBTRD_ADDR_CONFIG) begin
            config_reg <= reg_req.wdata;
        end
    end

    // reserved bit 2 is stored but reads back as zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gyro_cfg <= GBTRD_RESET_BYTE;
        end else if (ce && reg_req.wr && reg_req.addr == GBTRD_ADDR_GYRO_CFG) begin
            gyro_cfg <= reg_req.wdata; // RULE9
        end
    end

    // reads follow the address with no wait, so data stands as long as the address does
    always_comb begin
        case (reg_req.addr)
            GBTRD_ADDR_X_HIGH:   reg_rdata = trim_byte[0];
            GBTRD_ADDR_X_LOW:    reg_rdata = trim_byte[1];
            GBTRD_ADDR_Y_HIGH:   reg_rdata = trim_byte[2];
            GBTRD_ADDR_Y_LOW:    reg_rdata = trim_byte[3];
            GBTRD_ADDR_Z_HIGH:   reg_rdata = trim_byte[4];
            GBTRD_ADDR_Z_LOW:    reg_rdata = trim_byte[5];
            GBTRD_ADDR_DIVISOR:  reg_rdata = output_rate_divisor_value;
            GBTRD_ADDR_CONFIG:   reg_rdata = config_reg;
            GBTRD_ADDR_GYRO_CFG: reg_rdata = gyro_cfg & 8'hFB;
            default:             reg_rdata = 8'h00;
        endcase
    end

    assign filter_bypass_select = gyro_cfg[GBTRD_BYPASS_LSB +: 2]; // RULE9
    assign lowpass_setting      = config_reg[GBTRD_LOWPASS_LSB +: 3];
    assign divider_active       = divider_applies(filter_bypass_select, lowpass_setting); // RULE7

    // 1 khz base tick from the 50 mhz clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= 24'h000000;
        end else if (ce) begin
            if (tick_cnt == TICK_LAST) begin
                tick_cnt <= 24'h000000;
            end else begin
                tick_cnt <= tick_cnt + 24'h000001;
            end
        end
    end
    assign internal_tick = (tick_cnt == TICK_LAST); // RULE6

    // divisor writes take effect at the next wrap, so a divisor change never truncates a period
    always_comb begin
        next_strobe = 1'b0;
        if (internal_tick) begin
            next_strobe = !divider_active || (div_cnt == 8'h00); // RULE7
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 8'h00;
        end else if (ce && internal_tick) begin
            if (!divider_active || div_cnt == 8'h00) begin
                div_cnt <= output_rate_divisor_value; // RULE5
            end else begin
                div_cnt <= div_cnt - 8'h01;
            end
        end
    end

    // latest raw sample is held; only the divided strobe publishes it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            held_raw <= '0;
        end else if (ce && raw_valid) begin
            held_raw <= raw_sample;
        end
    end

    // wraps on overflow, matching plain 16-bit addition; no saturation
    assign raw_axis[0]  = held_raw.x;
    assign raw_axis[1]  = held_raw.y;
    assign raw_axis[2]  = held_raw.z;

    assign trim_axis[0] = x_bias_trim_value;
    assign trim_axis[1] = y_bias_trim_value;
    assign trim_axis[2] = z_bias_trim_value;

    genvar k;
    generate
        for (k = 0; k < 3; k++) begin : g_axis
            assign sum_axis[k] = raw_axis[k] + trim_axis[k]; // RULE4
        end
    endgenerate

    assign trimmed.x = sum_axis[0]; // RULE4
    assign trimmed.y = sum_axis[1]; // RULE4
    assign trimmed.z = sum_axis[2]; // RULE4

    // strobe and fifo write share one source so they can never disagree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_strobe <= 1'b0;
            fifo_write    <= 1'b0;
        end else if (ce) begin
            sample_strobe <= next_strobe; // RULE8
            fifo_write    <= next_strobe; // RULE8
        end
    end

    // data holds between strobes so a slow reader always sees one complete sample
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gyro_out <= '0;
        end else if (ce && next_strobe) begin
            gyro_out <= trimmed; // RULE4 RULE8
        end
    end

endmodule // gbtrd_core

// ### hw/gbtrd_pkg.sv
package gbtrd_pkg;

    localparam logic [7:0] GBTRD_ADDR_X_HIGH    = 8'h13;
    localparam logic [7:0] GBTRD_ADDR_X_LOW     = 8'h14;
    localparam logic [7:0] GBTRD_ADDR_Y_HIGH    = 8'h15;
    localparam logic [7:0] GBTRD_ADDR_Y_LOW     = 8'h16;
    localparam logic [7:0] GBTRD_ADDR_Z_HIGH    = 8'h17;
    localparam logic [7:0] GBTRD_ADDR_Z_LOW     = 8'h18;
    localparam logic [7:0] GBTRD_ADDR_DIVISOR   = 8'h19;
    localparam logic [7:0] GBTRD_ADDR_CONFIG    = 8'h1A;
    localparam logic [7:0] GBTRD_ADDR_GYRO_CFG  = 8'h1B;

    localparam int         GBTRD_LOWPASS_LSB    = 0;
    localparam int         GBTRD_BYPASS_LSB     = 0;
    localparam logic [2:0] GBTRD_LOWPASS_MAX    = 3'h7;
    localparam logic [1:0] GBTRD_BYPASS_OFF     = 2'h0;

    localparam logic [7:0] GBTRD_RESET_BYTE     = 8'h00;
    localparam logic [7:0] GBTRD_RESET_CONFIG   = 8'h80;

    localparam int         GBTRD_CLK_HZ         = 50000000;
    localparam int         GBTRD_INTERNAL_HZ    = 1000;
    localparam int         GBTRD_TICK_CYCLES    = GBTRD_CLK_HZ / GBTRD_INTERNAL_HZ;
    localparam int         GBTRD_TICK_W         = $clog2(GBTRD_TICK_CYCLES);

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gbtrd_reg_req_t;

    typedef struct packed {
        logic signed [15:0] x;
        logic signed [15:0] y;
        logic signed [15:0] z;
    } gbtrd_axes_t;

endpackage

// ### bench/gbtrd_checker.sv
`timescale 1ns/10ps
module gbtrd_checker #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic                      clk,
    input wire logic                      rst_n,
    input wire logic                      ce,
    input wire gbtrd_pkg::gbtrd_reg_req_t reg_req,
    input wire logic [7:0]                reg_rdata,
    input wire logic                      raw_valid,
    input wire gbtrd_pkg::gbtrd_axes_t    raw_sample,
    input wire gbtrd_pkg::gbtrd_axes_t    gyro_out,
    input wire logic                      sample_strobe,
    input wire logic                      fifo_write
);
    import gbtrd_pkg::*;
    logic       wr_d;
    logic [7:0] wa_d;
    logic [7:0] wd_d;
    logic       hit;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // last accepted write, compared only while the address still points at it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) wr_d <= 1'b0;
        else wr_d <= reg_req.wr && ce;
    end
    always_ff @(posedge clk) begin
        wa_d <= reg_req.addr;
        wd_d <= reg_req.wdata;
    end
    assign hit = wr_d && (reg_req.addr == wa_d);
    a_x_trim_rw: assert property (hit && wa_d inside {8'h13, 8'h14} |-> reg_rdata == wd_d)
        else $error("x trim readback wrong");
    a_y_trim_rw: assert property (hit && wa_d inside {8'h15, 8'h16} |-> reg_rdata == wd_d)
        else $error("y trim readback wrong");
    a_z_trim_rw: assert property (hit && wa_d inside {8'h17, 8'h18} |-> reg_rdata == wd_d)
        else $error("z trim readback wrong");
    a_divisor_rw: assert property (hit && wa_d == 8'h19 |-> reg_rdata == wd_d)
        else $error("divisor readback wrong");
    a_bypass_rw: assert property (hit && wa_d == 8'h1B |-> reg_rdata[1:0] == wd_d[1:0])
        else $error("bypass bits readback wrong");
    a_fifo_follows: assert property (fifo_write == sample_strobe)
        else $error("fifo write differs from strobe");
    a_out_holds: assert property (!sample_strobe |-> $stable(gyro_out))
        else $error("output moved without strobe");
    // the fastest rate is one strobe per internal tick of four cycles
    a_tick_gap: assert property (sample_strobe |=> !sample_strobe [*3])
        else $error("strobes closer than one tick");
    a_ce_freeze: assert property (!ce |=> $stable(gyro_out) && $stable(sample_strobe))
        else $error("outputs moved while clock enable low");
endmodule // gbtrd_checker

// ### bench/gbtrd_tb.sv
`timescale 1ns/10ps
module testbench;
    import gbtrd_pkg::*;
    logic           clk = 1'b0;
    logic           rst_n = 1'b0;
    logic           ce = 1'b1;
    gbtrd_reg_req_t reg_req = '0;
    logic           raw_valid = 1'b0;
    gbtrd_axes_t    raw_sample = '0;
    logic [7:0]     reg_rdata;
    gbtrd_axes_t    gyro_out;
    logic           sample_strobe;
    logic           fifo_write;
    int             mismatches = 0;
    int             checked = 0;
    int             cycles = 0;
    int             n;
    logic [7:0]     tv [6] = '{8'hFF, 8'hF0, 8'h01, 8'h00, 8'h7F, 8'hFF};
    logic [7:0]     cf [6] = '{8'h01, 8'h06, 8'h07, 8'h00, 8'h01, 8'h01};
    logic [7:0]     gc [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02};
    logic [7:0]     dv [6] = '{8'h02, 8'hFF, 8'h02, 8'h02, 8'h02, 8'h02};
    int             ex [6] = '{12, 1024, 4, 4, 4, 4};
    always #10 clk = ~clk;
    gbtrd_core #(.TICK_CYCLES(4)) gbtrd_core_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .raw_valid(raw_valid), .raw_sample(raw_sample), .gyro_out(gyro_out),
        .sample_strobe(sample_strobe), .fifo_write(fifo_write));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) reg_req <= '{1'b1, a, d};
        @(posedge clk) reg_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk) reg_req.addr <= a;
        #1 chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
    endtask
    // bounded so a dead strobe shows up as a wrong gap, not a hang
    task automatic gap(output int c);
        c = 0;
        do begin
            @(posedge clk);
            #1 c++;
        end while (sample_strobe !== 1'b1 && c < 1100);
    endtask
    task automatic wrap_up;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 9; i++) rd(8'(8'h13 + i), (i == 7) ? 8'h80 : 8'h00);
        rd(8'h20, 8'h00);
        wr(8'h1B, 8'hFF);
        rd(8'h1B, 8'hFB);
        for (int i = 0; i < 6; i++) wr(8'(8'h13 + i), tv[i]);
        for (int i = 0; i < 6; i++) rd(8'(8'h13 + i), tv[i]);
        @(posedge clk) raw_sample <= '{16'h0005, 16'hFF00, 16'h0002};
        raw_valid <= 1'b1;
        @(posedge clk) raw_valid <= 1'b0;
        gap(n);
        gap(n);
        chk("gyro_x", 16'hFFF5, gyro_out.x);
        chk("gyro_y", 16'h0000, gyro_out.y);
        chk("gyro_z", 16'h8001, gyro_out.z);
        // freeze just after a strobe: no strobe, no output change, no register write
        @(posedge clk) ce <= 1'b0;
        repeat (20) begin
            @(posedge clk);
            #1 chk("strobe_frozen", 16'h0000, {15'h0000, sample_strobe});
        end
        wr(8'h19, 8'h55);
        rd(8'h19, 8'h00);
        chk("gyro_frozen", 16'hFFF5, gyro_out.x);
        @(posedge clk) ce <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            wr(8'h1A, cf[i]);
            wr(8'h1B, gc[i]);
            wr(8'h19, dv[i]);
            repeat (3) gap(n);
            chk("strobe_gap", 16'(ex[i]), 16'(n));
        end
        wrap_up();
    end
endmodule // testbench
bind gbtrd_core gbtrd_checker #(.TICK_CYCLES(TICK_CYCLES)) gbtrd_checker_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .raw_valid(raw_valid), .raw_sample(raw_sample),
    .gyro_out(gyro_out), .sample_strobe(sample_strobe), .fifo_write(fifo_write));
